// ---- logic/fop_pkg.sv ----
// Types shared by the float operand preparation block
package fop_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_ADV = 5'h01, S_WAIT_HI = 5'h02, S_PTR = 5'h03,
    S_WAIT_LO = 5'h04, S_SHIFT = 5'h05, S_SHIFTHI = 5'h06, S_EXP = 5'h07,
    S_MANT = 5'h08, S_ZHI = 5'h09, S_DECODE = 5'h0a, S_XOR = 5'h0b,
    S_SUBTRACT_PRESTEP = 5'h0c, S_ADD_ENTRY_STEP = 5'h0d, S_NEGBH = 5'h0e, S_ALOW = 5'h0f,
    S_AHIGH = 5'h10, S_EXPSET = 5'h11, S_DIFF = 5'h12, S_SWAP1 = 5'h13,
    S_SWAP2 = 5'h14, S_SWAP3 = 5'h15, S_SWAP4 = 5'h16, S_DONE = 5'h17
  } state_type;
  typedef enum logic [1:0] {
    OP_ADD = 2'h0, OP_SUB = 2'h1, OP_MUL = 2'h2, OP_DIV = 2'h3
  } fop_type;
  typedef struct packed {
    logic [15:0][15:0] gpr;
  } regfile_type;
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_type;
endpackage

// ---- logic/fop_prep.sv ----
// Float operand fetch completion, sign setup and add/subtract preparation
// How it works
// - Hidden one kept only for nonzero exponent; zero exponent zeroes operand.
// - After B fetch: sign to hold register and N flag, advance pointer, read.
// - Second-operand flag forces register address even: 10, 12, 14.
// - A pass moves B-exponent-zero from Z into held bit, Z gets A zeroness.
// - End of A pass clears the second-operand flag.
// - High A word into B latch, decode and dispatch the operation.
// - Result sign is high A xor held high B; held B copied to bus hold.
// - Subtract prestep at microword 522 inverts high B into bus hold.
// - Add entry at 520 loads low B into latch, tests bus hold bit 15.
// - Negative B gets a 32-bit two's complement, carry chained low to high.
// - Negative A is two's complemented; low to shift register, high to bus hold.
// - Low A conversion also samples the synchronised transfer request.
// - High A to staging, A exponent to latch, Z cleared before compare.
// - Difference B minus A exponent is shift count; bit 15 flags A larger.
// - A larger: negate difference, swap low and high words, copy A exponent to B.
// - Zero difference sets Z to record equal exponents.
// - Swap loads the positive difference from bus hold into shift counter.
// - Swap moves only the A exponent into the B exponent register.
// - First pass exponent lives in register 15; Z set if it is zero.
`include "fop_regs.svh"
module fop_prep
  import fop_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic START_I,
  input wire logic [1:0] FOP_I,
  input wire logic [2:0] STACK_REG_I,
  output logic MEM_RD_O,
  output logic [15:0] MEM_ADDR_O,
  input wire logic [15:0] MEM_DATA_I,
  input wire logic MEM_DONE_I,
  input wire logic NPR_REQ_I,
  input wire logic [4:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [1:0] DISPATCH_O,
  output logic RESULT_SIGN_O,
  output logic NEG_FLAG_O,
  output logic ZERO_FLAG_O,
  output logic EXP_ZERO_B_O,
  output logic SECOND_OPERAND_O,
  output logic NPR_SEEN_O,
  output logic [15:0] SHIFT_COUNT_O,
  output logic [9:0] UWORD_O
);
  typedef struct packed {
    state_type st;
    fop_type op;
    logic [15:0] sign_hold, bus_hold, staging, blatch, low_shift, shift_count;
    logic carry, nflag, zflag, zb, argsel, npr_seen, result_sign, done, mem_rd;
    logic [15:0] mem_addr, rdata;
    logic [9:0] uword;
  } state_rec_type;
  state_rec_type r, next_r;
  logic [15:0][15:0] rf;
  logic we, npr_s;
  logic [3:0] waddr, sp_idx;
  logic [15:0] wdata, diff;
  logic [16:0] sum;
  fop_regfile u_regfile (.clk_i(CLK_SYS_I), .srst_i(SRST_I), .we_i(we),
    .waddr_i(waddr), .wdata_i(wdata), .regs_o(rf));
  fop_sync u_npr_sync (.clk_i(CLK_SYS_I), .srst_i(SRST_I), .d_i(NPR_REQ_I),
    .q_o(npr_s));
  // Microcode names odd registers; the flag steers them to the even twin
  function automatic logic [3:0] gsel(input logic [3:0] idx,
                                      input logic arg);
    gsel = {idx[3:1], idx[0] & ~arg};
  endfunction
  assign sp_idx = {1'b0, STACK_REG_I};
  assign diff = rf[`FOP_R_EXP_B] - r.blatch;
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.mem_rd = 1'b0;
    we = 1'b0;
    waddr = 4'h0;
    wdata = 16'h0000;
    sum = 17'h00000;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `FOP_ADR_BUS_HOLD: next_r.rdata = r.bus_hold;
        `FOP_ADR_SIGN_HOLD: next_r.rdata = r.sign_hold;
        `FOP_ADR_LOW_SHIFT: next_r.rdata = r.low_shift;
        `FOP_ADR_STAGING: next_r.rdata = r.staging;
        default: next_r.rdata = REG_ADDR_I[4] ? 16'h0000 : rf[REG_ADDR_I[3:0]];
      endcase
    end
    case (r.st)
      S_IDLE: begin
        if (START_I) begin
          next_r.op = fop_type'(FOP_I);
          next_r.zflag = (rf[`FOP_R_EXP_B] == 16'h0000);
          next_r.sign_hold = r.bus_hold;
          next_r.nflag = r.bus_hold[`FOP_SIGN_BIT];
          next_r.argsel = 1'b1;
          next_r.st = S_ADV;
        end else if (REG_WR_I) begin
          // Preload path for the B operand, pointer and bus hold
          if (REG_ADDR_I == `FOP_ADR_BUS_HOLD) begin
            next_r.bus_hold = REG_WDATA_I;
          end else if (!REG_ADDR_I[4]) begin
            we = 1'b1;
            waddr = REG_ADDR_I[3:0];
            wdata = REG_WDATA_I;
          end
        end
      end
      S_ADV, S_PTR: begin
        // Clock stop while memory answers is a wait state here
        we = 1'b1;
        waddr = sp_idx;
        wdata = rf[sp_idx] + `FOP_PTR_STEP;
        next_r.mem_addr = wdata;
        next_r.mem_rd = 1'b1;
        next_r.st = (r.st == S_ADV) ? S_WAIT_HI : S_WAIT_LO;
      end
      S_WAIT_HI: begin
        if (MEM_DONE_I) begin
          we = 1'b1;
          waddr = gsel(`FOP_R_HI_B, r.argsel);
          wdata = MEM_DATA_I;
          next_r.bus_hold = MEM_DATA_I;
          next_r.blatch = MEM_DATA_I;
          next_r.staging = MEM_DATA_I;
          next_r.st = S_PTR;
        end
      end
      S_WAIT_LO: begin
        if (MEM_DONE_I) begin
          we = 1'b1;
          waddr = gsel(`FOP_R_LO_B, r.argsel);
          wdata = MEM_DATA_I;
          next_r.blatch = MEM_DATA_I;
          next_r.st = S_SHIFT;
        end
      end
      S_SHIFT: begin
        sum = {1'b0, r.blatch} + {1'b0, r.blatch};
        we = 1'b1;
        waddr = gsel(`FOP_R_LO_B, r.argsel);
        wdata = sum[15:0];
        next_r.carry = sum[16];
        next_r.st = S_SHIFTHI;
      end
      S_SHIFTHI: begin
        // Sign drops out here but is still kept in bus hold
        next_r.blatch = {r.staging[14:0], r.carry};
        we = 1'b1;
        waddr = gsel(`FOP_R_HI_B, r.argsel);
        wdata = next_r.blatch;
        next_r.st = S_EXP;
      end
      S_EXP: begin
        we = 1'b1;
        waddr = gsel(`FOP_R_EXP_B, r.argsel);
        wdata = {8'h00, r.blatch[15:8]};
        next_r.zb = r.zflag;
        next_r.zflag = (r.blatch[15:8] == 8'h00);
        next_r.st = S_MANT;
      end
      S_MANT: begin
        we = 1'b1;
        if (r.zflag) begin
          waddr = gsel(`FOP_R_LO_B, r.argsel);
          wdata = 16'h0000;
          next_r.blatch = 16'h0000;
          next_r.st = S_ZHI;
        end else begin
          waddr = gsel(`FOP_R_HI_B, r.argsel);
          wdata = {8'h00, r.blatch[7:0]} | `FOP_HIDDEN_ONE;
          next_r.argsel = 1'b0;
          next_r.st = S_DECODE;
        end
      end
      S_ZHI: begin
        we = 1'b1;
        waddr = gsel(`FOP_R_HI_B, r.argsel);
        wdata = 16'h0000;
        next_r.argsel = 1'b0;
        next_r.st = S_DECODE;
      end
      S_DECODE: begin
        next_r.blatch = r.staging;
        next_r.st = S_XOR;
      end
      S_XOR: begin
        next_r.result_sign = r.blatch[`FOP_SIGN_BIT] ^
                             r.sign_hold[`FOP_SIGN_BIT];
        next_r.bus_hold = r.sign_hold;
        case (r.op)
          OP_ADD: begin
            next_r.uword = `FOP_ADD_UWORD;
            next_r.st = S_ADD_ENTRY_STEP;
          end
          OP_SUB: begin
            next_r.uword = `FOP_SUB_UWORD;
            next_r.st = S_SUBTRACT_PRESTEP;
          end
          default: next_r.st = S_DONE;
        endcase
      end
      S_SUBTRACT_PRESTEP: begin
        next_r.bus_hold = ~r.sign_hold;
        next_r.uword = `FOP_ADD_UWORD;
        next_r.st = S_ADD_ENTRY_STEP;
      end
      S_ADD_ENTRY_STEP: begin
        next_r.blatch = rf[`FOP_R_LO_B];
        sum = {1'b0, ~rf[`FOP_R_LO_B]} + 17'h00001;
        if (r.bus_hold[`FOP_SIGN_BIT]) begin
          we = 1'b1;
          waddr = `FOP_R_LO_B;
          wdata = sum[15:0];
          next_r.carry = sum[16];
          next_r.st = S_NEGBH;
        end else begin
          next_r.st = S_ALOW;
        end
      end
      S_NEGBH: begin
        sum = {1'b0, ~rf[`FOP_R_HI_B]} + {16'h0000, r.carry};
        we = 1'b1;
        waddr = `FOP_R_HI_B;
        wdata = sum[15:0];
        next_r.st = S_ALOW;
      end
      S_ALOW: begin
        // Long operation: give waiting transfers a chance here
        next_r.npr_seen = npr_s;
        sum = {1'b0, ~rf[`FOP_R_LO_A]} + 17'h00001;
        if (r.staging[`FOP_SIGN_BIT]) begin
          next_r.low_shift = sum[15:0];
          next_r.carry = sum[16];
          next_r.st = S_AHIGH;
        end else begin
          next_r.low_shift = rf[`FOP_R_LO_A];
          next_r.bus_hold = rf[`FOP_R_HI_A];
          next_r.st = S_EXPSET;
        end
      end
      S_AHIGH: begin
        sum = {1'b0, ~rf[`FOP_R_HI_A]} + {16'h0000, r.carry};
        next_r.bus_hold = sum[15:0];
        next_r.st = S_EXPSET;
      end
      S_EXPSET: begin
        next_r.staging = r.bus_hold;
        next_r.blatch = rf[`FOP_R_EXP_A];
        next_r.zflag = 1'b0;
        next_r.st = S_DIFF;
      end
      S_DIFF: begin
        next_r.bus_hold = diff;
        next_r.blatch = diff;
        if (diff[`FOP_SIGN_BIT]) begin
          next_r.st = S_SWAP1;
        end else begin
          next_r.shift_count = diff;
          next_r.zflag = (diff == 16'h0000);
          next_r.st = S_DONE;
        end
      end
      S_SWAP1: begin
        next_r.bus_hold = 16'h0000 - r.bus_hold;
        next_r.st = S_SWAP2;
      end
      S_SWAP2: begin
        next_r.shift_count = r.bus_hold;
        we = 1'b1;
        waddr = `FOP_R_LO_B;
        wdata = r.low_shift;
        next_r.low_shift = rf[`FOP_R_LO_B];
        next_r.st = S_SWAP3;
      end
      S_SWAP3: begin
        we = 1'b1;
        waddr = `FOP_R_HI_B;
        wdata = r.staging;
        next_r.staging = rf[`FOP_R_HI_B];
        next_r.st = S_SWAP4;
      end
      S_SWAP4: begin
        // Smaller B exponent is dropped; its difference is already counted
        we = 1'b1;
        waddr = `FOP_R_EXP_B;
        wdata = rf[`FOP_R_EXP_A];
        next_r.st = S_DONE;
      end
      S_DONE: begin
        next_r.done = 1'b1;
        next_r.st = S_IDLE;
      end
      default: next_r.st = S_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign MEM_RD_O = r.mem_rd;
  assign MEM_ADDR_O = r.mem_addr;
  assign REG_RDATA_O = r.rdata;
  assign BUSY_O = (r.st != S_IDLE);
  assign DONE_O = r.done;
  assign DISPATCH_O = r.op;
  assign RESULT_SIGN_O = r.result_sign;
  assign NEG_FLAG_O = r.nflag;
  assign ZERO_FLAG_O = r.zflag;
  assign EXP_ZERO_B_O = r.zb;
  assign SECOND_OPERAND_O = r.argsel;
  assign NPR_SEEN_O = r.npr_seen;
  assign SHIFT_COUNT_O = r.shift_count;
  assign UWORD_O = r.uword;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  AST_ZERO_EXP_CLEARS: assert property (
    (r.st == S_MANT && r.zflag) |=> ##1 (rf[`FOP_R_LO_A] == 16'h0000 &&
      rf[`FOP_R_HI_A] == 16'h0000)) else $error("zero operand not cleared");
  AST_SIGN_SAVED: assert property (
    (r.st == S_IDLE && START_I) |=> (NEG_FLAG_O == $past(r.bus_hold[15]))
      ##1 MEM_RD_O) else $error("B sign not saved before A read");
  AST_EVEN_LOW: assert property (
    (r.st == S_WAIT_LO && MEM_DONE_I) |=>
      rf[`FOP_R_LO_A] == $past(MEM_DATA_I)) else $error("low A misplaced");
  AST_ZB_MOVE: assert property (
    r.st == S_EXP |=> EXP_ZERO_B_O == $past(r.zflag))
    else $error("held exponent-zero bit wrong");
  AST_ARG_CLEAR: assert property (
    r.st == S_DECODE |-> !SECOND_OPERAND_O)
    else $error("second operand flag still set");
  AST_RESULT_SIGN: assert property (
    r.st == S_XOR |=> RESULT_SIGN_O == ($past(r.blatch[15]) ^
      $past(r.sign_hold[15]))) else $error("result sign wrong");
  AST_SUB_INVERT: assert property (
    r.st == S_SUBTRACT_PRESTEP |=> (r.bus_hold == ~$past(r.sign_hold) &&
      $past(UWORD_O) == `FOP_SUB_UWORD && UWORD_O == `FOP_ADD_UWORD))
    else $error("subtrahend not inverted");
  AST_NEG_B: assert property (
    (r.st == S_ADD_ENTRY_STEP && r.bus_hold[15]) |=> ##1
      ({rf[`FOP_R_HI_B], rf[`FOP_R_LO_B]} ==
       32'h00000000 - $past({rf[`FOP_R_HI_B], rf[`FOP_R_LO_B]}, 2)))
    else $error("B mantissa not negated");
  AST_NPR_SAMPLE: assert property (
    r.st == S_ALOW |=> NPR_SEEN_O == $past(npr_s))
    else $error("transfer request not sampled");
  AST_EQUAL_EXP: assert property (
    (r.st == S_DIFF && diff == 16'h0000) |=> ZERO_FLAG_O ##1 DONE_O)
    else $error("equal exponents not flagged");
  AST_SWAP_EXP: assert property (
    r.st == S_SWAP1 |=> ##3 (rf[`FOP_R_EXP_B] == $past(rf[`FOP_R_EXP_A], 3)
      && SHIFT_COUNT_O[15] == 1'b0)) else $error("swap exponent wrong");
  COV_ADD: cover property (r.st == S_XOR && r.op == OP_ADD ##[1:20] DONE_O);
  COV_SUB: cover property (r.st == S_SUBTRACT_PRESTEP ##[1:20] DONE_O);
  COV_MUL: cover property (r.st == S_XOR && r.op == OP_MUL ##2 DONE_O);
  COV_SWAP: cover property (r.st == S_SWAP4 ##2 DONE_O);
endmodule

// ---- logic/fop_regfile.sv ----
// Sixteen general registers in flip-flops, one write port
module fop_regfile
  import fop_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0][15:0] regs_o
);
  regfile_type r;
  regfile_type next_r;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_word
      always_comb begin
        next_r.gpr[g] = (we_i && waddr_i == 4'(g)) ? wdata_i : r.gpr[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign regs_o = r.gpr;
endmodule

// ---- logic/fop_regs.svh ----
// Offsets, indices and constants of the float operand preparation block
`ifndef FOP_REGS_SVH
`define FOP_REGS_SVH
`define FOP_R_HI_B 4'hb
`define FOP_R_LO_B 4'hd
`define FOP_R_EXP_B 4'hf
`define FOP_R_HI_A 4'ha
`define FOP_R_LO_A 4'hc
`define FOP_R_EXP_A 4'he
`define FOP_SIGN_BIT 15
`define FOP_HIDDEN_ONE 16'h0100
`define FOP_PTR_STEP 16'h0002
`define FOP_ADD_UWORD 10'h150
`define FOP_SUB_UWORD 10'h152
`define FOP_ADR_BUS_HOLD 5'h10
`define FOP_ADR_SIGN_HOLD 5'h11
`define FOP_ADR_LOW_SHIFT 5'h12
`define FOP_ADR_STAGING 5'h13
`endif

// ---- logic/fop_sync.sv ----
// Two-flop synchroniser for the transfer request pin
module fop_sync
  import fop_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  sync_type r;
  sync_type next_r;

  always_comb begin
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.s2;
endmodule

// ---- testbench/float_operand_fetch_align_prep_test.sv ----
// Self-checking bench for the float operand preparation block
`include "fop_regs.svh"
module float_operand_fetch_align_prep_test
  import fop_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    string name;
    logic [33:0] exp;
    logic [33:0] mask;
  } note_type;
  note_type notes[$];
  logic clk = 1'b0, srst = 1'b1, start = 1'b0, rd = 1'b0, wr = 1'b0;
  logic non_processor_transfer_request = 1'b0, pend = 1'b0, pbusy = 1'b0;
  logic [1:0] fop = 2'h0;
  logic [2:0] sreg = 3'h0;
  logic [4:0] raddr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] delay = 4'h0;
  logic [15:0] rdata, maddr, mdata, shift_count;
  logic mrd, mdone, done, rsign, negf, zerof, ezb, sec, nprs, busy;
  logic [1:0] disp;
  logic [9:0] uword;
  logic [31:0] seed = 32'heb70;
  logic [4:0] ra [6] = '{5'h00, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h1f};
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  fop_prep fop_prep_inst (.CLK_SYS_I(clk), .SRST_I(srst), .START_I(start),
    .FOP_I(fop), .STACK_REG_I(sreg), .MEM_RD_O(mrd), .MEM_ADDR_O(maddr),
    .MEM_DATA_I(mdata), .MEM_DONE_I(mdone), .NPR_REQ_I(non_processor_transfer_request),
    .REG_ADDR_I(raddr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .BUSY_O(busy), .DONE_O(done), .DISPATCH_O(disp),
    .RESULT_SIGN_O(rsign), .NEG_FLAG_O(negf), .ZERO_FLAG_O(zerof),
    .EXP_ZERO_B_O(ezb), .SECOND_OPERAND_O(sec), .NPR_SEEN_O(nprs),
    .SHIFT_COUNT_O(shift_count), .UWORD_O(uword));

  fop_mem_model fop_mem_model_inst (.clk_i(clk), .rd_i(mrd), .addr_i(maddr),
    .delay_i(delay), .done_o(mdone), .data_o(mdata));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Exponent, high mantissa with hidden one, low mantissa shifted left
  function automatic logic [39:0] prep(input logic [15:0] h, l);
    logic [15:0] mh;
    mh = 16'h0100 | {8'h00, h[6:0], l[15]};
    if (h[14:7] == 8'h00) return 40'h0;
    return {h[14:7], mh, l[14:0], 1'b0};
  endfunction

  task automatic conclude();
    if (notes.size() != 0) num_errors++;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic take(input logic [33:0] seen);
    note_type t;
    n_checks++;
    if (notes.size() == 0) begin
      num_errors++;
      $display("unexpected result: expected none, seen %h", seen);
      return;
    end
    t = notes.pop_front();
    if ((seen & t.mask) !== (t.exp & t.mask)) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", t.name,
        t.exp & t.mask, seen & t.mask);
    end
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    raddr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [4:0] a, input logic [15:0] e,
    input string n);
    @(posedge clk);
    raddr <= a;
    rd <= 1'b1;
    notes.push_back('{n, {18'h0, e}, {18'h0, 16'hffff}});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Read data lands one cycle after the strobe; flags stand with done
  always @(negedge clk) begin
    if (pend) take({18'h0, rdata});
    if (done === 1'b1) begin
      take({disp, rsign, negf, zerof, ezb, sec, nprs, uword, shift_count});
      take({32'h0, pbusy, busy});
    end
    pend = rd;
    pbusy = busy;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic run(input int i);
    logic [15:0] ha, la, hb, lb, mha, mla, mhb, mlb, ah, al, bh, bl, df, bp;
    logic [7:0] ea, eb;
    logic [2:0] sp;
    logic sw, nv;
    logic [33:0] ev, m;
    fop_type op;
    ha = 16'(rnd());
    la = 16'(rnd());
    hb = 16'(rnd());
    lb = 16'(rnd());
    bp = 16'(rnd()) & 16'hffe0;
    sp = 3'(rnd());
    delay <= 4'(rnd() % 4);
    op = fop_type'(i % 4);
    nv = (i == 9);
    if (i < 2) begin
      ha[14] = (i == 0);
      hb[14] = (i == 1);
    end
    if (i == 2 || i == 4) ha[14:7] = 8'h00;
    if (i == 5 || i == 7) hb[14:7] = 8'h00;
    if (i == 8) ha[14:7] = hb[14:7];
    {ea, mha, mla} = prep(ha, la);
    {eb, mhb, mlb} = prep(hb, lb);
    {ah, al} = ha[15] ? -{mha, mla} : {mha, mla};
    {bh, bl} = (hb[15] ^ (op == OP_SUB)) ? -{mhb, mlb} : {mhb, mlb};
    df = {8'h00, eb} - {8'h00, ea};
    sw = df[15];
    fop_mem_model_inst.mem[1] = ha;
    fop_mem_model_inst.mem[2] = la;
    wreg({1'b0, `FOP_R_HI_B}, mhb);
    wreg({1'b0, `FOP_R_LO_B}, mlb);
    wreg({1'b0, `FOP_R_EXP_B}, {8'h00, eb});
    wreg(`FOP_ADR_BUS_HOLD, hb);
    wreg({2'b00, sp}, bp);
    wreg({2'b00, ~sp}, 16'h1234);
    ev = {op, ha[15] ^ hb[15], hb[15], (op[1] ? ea == 8'h00 : df == 16'h0),
      eb == 8'h00, 1'b0, nv, `FOP_ADD_UWORD,
      (sw ? -df : df)};
    m = op[1] ? {7'h7f, 27'h0} : {34{1'b1}};
    notes.push_back('{"flags", ev, m});
    notes.push_back('{"busy", 34'h2, 34'h3});
    @(posedge clk);
    fop <= op;
    sreg <= sp;
    non_processor_transfer_request <= nv;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    raddr <= {2'b00, ~sp};
    wdata <= 16'hffff;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    while (done !== 1'b1) @(negedge clk);
    @(posedge clk);
    non_processor_transfer_request <= 1'b0;
    rreg({2'b00, sp}, bp + 16'h0004, "pointer");
    rreg({2'b00, ~sp}, 16'h1234, "busy write");
    rreg({1'b0, `FOP_R_EXP_A}, {8'h00, ea}, "a exponent");
    if (op[1]) begin
      rreg({1'b0, `FOP_R_HI_A}, mha, "a high");
      rreg({1'b0, `FOP_R_LO_A}, mla, "a low");
    end else begin
      rreg({1'b0, `FOP_R_HI_B}, sw ? ah : bh, "b high");
      rreg({1'b0, `FOP_R_LO_B}, sw ? al : bl, "b low");
      rreg({1'b0, `FOP_R_EXP_B}, {8'h00, sw ? ea : eb}, "b exp");
      rreg(`FOP_ADR_LOW_SHIFT, sw ? bl : al, "low shift");
      rreg(`FOP_ADR_STAGING, sw ? bh : ah, "staging");
      rreg(`FOP_ADR_BUS_HOLD, sw ? -df : df, "bus hold");
    end
    $display("test %0d op %0d swap %0d done", i, op, sw);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Read-only and unmapped places must ignore writes
    wreg(`FOP_ADR_SIGN_HOLD, 16'hffff);
    wreg(`FOP_ADR_STAGING, 16'hffff);
    wreg(5'h1f, 16'hffff);
    foreach (ra[k]) rreg(ra[k], 16'h0000, "reset value");
    $display("reset test done");
    for (int i = 0; i < 10; i++) run(i);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule

// ---- testbench/fop_mem_model.sv ----
// Stack memory model that answers block reads after a chosen delay
module fop_mem_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] delay_i,
  output logic done_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [15:0] addr = 16'h0000;
  int cnt = -1;

  // Distinct filler so a wrong address shows up as wrong data
  initial begin
    done_o = 1'b0;
    data_o = 16'hffff;
    for (int k = 0; k < 16; k++) begin
      mem[k] = 16'h5a00 + 16'(k);
    end
  end

  // Off-cycle data is the inverse of the last word, never a stale copy
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~last;
    if (rd_i) begin
      addr <= addr_i;
      cnt <= int'(delay_i);
    end else if (cnt == 0) begin
      done_o <= 1'b1;
      data_o <= mem[addr[4:1]];
      last <= mem[addr[4:1]];
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
